// file: testbench/csf_core_props.sv
// Purpose: port assertions for csf_core
// Assumes: one clock, sync reset
// Notes:   bound to the core below
////////////////////////////////////////////////////////////////////////////////
module csf_core_props
  import csf_pkg::*;
(
  input wire logic       clk_i,         // Clock
  input wire logic       rst_i,         // Reset
  input wire csf_instr_s instr_i,       // Instruction
  input wire logic       wdt_clear_i,   // Clear
  input wire logic       sleep_i,       // Sleep
  input wire logic       wdt_timeout_i, // Time-out
  input wire logic [8:0] data_addr_o,   // Address
  input wire logic [7:0] status_o,      // Status
  input wire logic       status_hit_o,  // Status hit
  input wire logic       wb_cyc_i,      // Cycle
  input wire logic       wb_stb_i,      // Strobe
  input wire logic       wb_ack_o       // Ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [6:0] low_ofs;
  // Low seven bits of the accessed data address, same in every bank
  assign low_ofs = instr_i.indirect ? instr_i.fsr[6:0] : instr_i.dir_addr;
  // Reference add of the two operands
  assign sum = instr_i.a + instr_i.b;
  assign nib = instr_i.a[3:0] + instr_i.b[3:0];
  sequence s_add;
    instr_i.valid && instr_i.op == CSF_OP_ADD_W_FILE;
  endsequence
  sequence s_keep;
    instr_i.valid && !wb_cyc_i && !instr_i.dest_file &&
      instr_i.op inside {CSF_OP_BIT_CLEAR, CSF_OP_BIT_SET, CSF_OP_NIBBLE_SWAP};
  endsequence
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ro_bits_steady: assert property (
    !wdt_clear_i && !sleep_i && !wdt_timeout_i |=> $stable(status_o[4:3]))
    else $error("read-only bits moved");
  a_sleep_flags: assert property (
    sleep_i && !wdt_clear_i && !wdt_timeout_i |=> status_o[4:3] == 2'b10)
    else $error("sleep flags wrong");
  a_timeout_clears: assert property (wdt_timeout_i |=> !status_o[4])
    else $error("time-out not seen");
  a_clear_sets: assert property (
    wdt_clear_i && !sleep_i && !wdt_timeout_i |=> status_o[4:3] == 2'b11)
    else $error("clear flags wrong");
  a_direct_addr: assert property (instr_i.valid && !instr_i.indirect |=>
    data_addr_o == {$past(status_o[6:5]), $past(instr_i.dir_addr)}) else $error("bad addr");
  a_indirect_addr: assert property (instr_i.valid && instr_i.indirect |=>
    data_addr_o == {$past(status_o[7]), $past(instr_i.fsr)}) else $error("bad ind addr");
  a_add_flags: assert property (s_add |=> status_o[2:0] ==
    {$past(sum[7:0]) == 8'h00, $past(nib[4]), $past(sum[8])}) else $error("add flags");
  a_keep_flags: assert property (s_keep |=> $stable(status_o[2:0]))
    else $error("flags disturbed");
  a_hit_mirror: assert property (
    instr_i.valid |-> status_hit_o == (low_ofs == STATUS_DIRECT_OFS))
    else $error("status hit wrong");
  a_clear_protect: assert property (instr_i.valid && instr_i.dest_file &&
    low_ofs == STATUS_DIRECT_OFS && instr_i.op == CSF_OP_CLEAR_FILE |=>
    status_o[2:0] == {1'b1, $past(status_o[1:0])}) else $error("flags not protected");
endmodule // csf_core_props

bind csf_core csf_core_props u_props (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i),
  .wdt_clear_i(wdt_clear_i), .sleep_i(sleep_i), .wdt_timeout_i(wdt_timeout_i),
  .data_addr_o(data_addr_o), .status_o(status_o), .status_hit_o(status_hit_o),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// file: testbench/csf_core_tb.sv
// Purpose: self-checking bench for csf_core
// Assumes: 50 MHz clock, 3-cycle reset
// Notes:   instructions come from csf_exec_model
////////////////////////////////////////////////////////////////////////////////
module csf_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csf_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [7:0]  wd = 8'h00;
  logic [31:0] rd, rdat;
  logic [7:0]  result, status;
  logic [8:0]  daddr;
  logic        ack, hit;
  logic [2:0]  evt;
  csf_instr_s  instr;
  int          n_errors = 0;
  int          checks_done = 0;
  csf_op_e     ops[4] = '{CSF_OP_ADD_W_FILE, CSF_OP_SUB_LITERAL, CSF_OP_SUB_W_FILE,
                          CSF_OP_ADD_LITERAL};
  logic [7:0]  ta[4] = '{8'h0f, 8'h03, 8'h05, 8'hff};
  logic [7:0]  tr[4] = '{8'h10, 8'hfe, 8'h00, 8'h00};
  logic [2:0]  tf[4] = '{3'b010, 3'b000, 3'b111, 3'b111};
  csf_op_e     kops[3] = '{CSF_OP_BIT_CLEAR, CSF_OP_BIT_SET, CSF_OP_NIBBLE_SWAP};
  // Clock
  always #10 clk_i = ~clk_i;
  csf_exec_model u_exec (.clk_i(clk_i), .instr_o(instr), .evt_o(evt));
  csf_core dut (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr), .wdt_timeout_i(evt[0]),
    .sleep_i(evt[1]), .wdt_clear_i(evt[2]), .result_o(result), .data_addr_o(daddr),
    .status_hit_o(hit), .status_o(status), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i({24'h0, wd}),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  // Direct-addressed instruction
  task automatic op(input csf_op_e o, input logic [7:0] a, b, input logic dst,
                    input logic [6:0] ad);
    u_exec.issue('{1'b1, o, a, b, 3'h2, dst, 1'b0, 8'h00, ad});
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    #1000000;
    n_errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, WB_OFS_STATUS, 8'h00);
    check(rd, 32'h18);
    wb(1'b1, WB_OFS_STATUS, 8'h00);
    wb(1'b0, WB_OFS_STATUS, 8'h00);
    check(rd, 32'h18);
    wb(1'b0, 4'h8, 8'h00);
    check(rd, 32'h0);
    for (int k = 0; k < 4; k++) begin
      op(CSF_OP_MOVE_W_TO_FILE, 8'h00, {1'b0, k[1:0], 5'h05}, 1'b1, STATUS_DIRECT_OFS);
      check(status, {1'b0, k[1:0], 5'h1d});
      op(CSF_OP_MOVE_W_TO_FILE, 8'h00, 8'h55, 1'b0, 7'h21);
      check(daddr, {k[1:0], 7'h21});
    end
    wb(1'b1, WB_OFS_STATUS, 8'h80);
    u_exec.issue('{1'b1, CSF_OP_MOVE_W_TO_FILE, 8'h0, 8'h0, 3'h0, 1'b0, 1'b1, 8'h45, 7'h0});
    #1;
    check(daddr, 9'h145);
    for (int i = 0; i < 4; i++) begin
      op(ops[i], ta[i], (i == 0 || i == 3) ? 8'h01 : 8'h05, 1'b0, 7'h20);
      check(result, tr[i]);
      check(status[2:0], tf[i]);
    end
    for (int i = 0; i < 3; i++) begin
      op(kops[i], 8'h00, 8'h00, 1'b0, 7'h20);
      check(status[2:0], 3'b111);
    end
    op(CSF_OP_LOGIC, 8'hff, 8'h0f, 1'b0, 7'h20);
    check(status[2:0], 3'b011);
    op(CSF_OP_ADD_W_FILE, 8'hef, 8'h01, 1'b1, STATUS_DIRECT_OFS);
    check(status, 8'hfa);
    op(CSF_OP_CLEAR_FILE, 8'h00, 8'h00, 1'b1, STATUS_DIRECT_OFS);
    check(status, 8'h1e);
    op(CSF_OP_ROTATE_RIGHT, 8'h01, 8'h00, 1'b0, 7'h20);
    check(status[0], 1'b1);
    op(CSF_OP_ROTATE_LEFT, 8'h7f, 8'h00, 1'b0, 7'h20);
    check(status[0], 1'b0);
    u_exec.pulse(3'h2);
    #1;
    check(status[4:3], 2'b10);
    u_exec.pulse(3'h1);
    #1;
    check(status[4], 1'b0);
    u_exec.pulse(3'h4);
    #1;
    check(status[4:3], 2'b11);
    wb(1'b0, WB_OFS_EVENT, 8'h00);
    check(rd, 32'h7);
    wb(1'b1, WB_OFS_EVENT, 8'h07);
    wb(1'b0, WB_OFS_EVENT, 8'h00);
    check(rd, 32'h0);
    tally_and_finish();
  end
endmodule // csf_core_tb

// file: testbench/csf_exec_model.sv
// Purpose: execution datapath model feeding csf_core
// Assumes: one instruction per call, idle cycle after it
// Notes:   idle fields are inverted so stale values never look current
////////////////////////////////////////////////////////////////////////////////
module csf_exec_model
  import csf_pkg::*;
(
  input  wire logic       clk_i,   // Core clock
  output var csf_instr_s  instr_o, // Instruction request
  output var logic [2:0]  evt_o    // Time-out, sleep, clear
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at start
  initial begin
    instr_o = '0;
    evt_o   = 3'h0;
  end
  // One instruction for one edge, then scrambled idle fields
  task automatic issue(input csf_instr_s ins);
    @(posedge clk_i);
    instr_o <= ins;
    @(posedge clk_i);
    instr_o <= {1'b0, ~ins[$bits(ins)-2:0]};
  endtask
  // One-cycle event pulse
  task automatic pulse(input logic [2:0] e);
    @(posedge clk_i);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= 3'h0;
  endtask
endmodule // csf_exec_model

// file: verilog/csf_alu.sv
// Purpose: result and flag computation for status-affecting operations
// Assumes: purely combinational, 8-bit operands
// Notes:   subtraction is a plus two's complement, flags are no-borrow
////////////////////////////////////////////////////////////////////////////////
module csf_alu
  import csf_pkg::*;
(
  input  csf_op_e    op_i,      // Operation
  input  wire logic [7:0] a_i,  // File operand
  input  wire logic [7:0] b_i,  // W or literal operand
  input  wire logic [2:0] bit_i,// Bit index
  input  wire logic   c_in_i,   // Current carry
  output csf_alu_s   out_o      // Result and flags
);

  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] addend;
  logic [7:0] base;
  logic       is_sub;

  // Operand selection for add and subtract
  always_comb begin
    is_sub = (op_i == CSF_OP_SUB_W_FILE) || (op_i == CSF_OP_SUB_LITERAL);
    // two's complement subtract: file/literal minus W
    base    = a_i;
    addend  = is_sub ? ~b_i : b_i;
    sum     = {1'b0, base} + {1'b0, addend} + {8'h00, is_sub};
    low_sum = {1'b0, base[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
  end

  // Result and flag decode
  always_comb begin
    out_o = '0;
    unique case (op_i)
      CSF_OP_ADD_W_FILE, CSF_OP_ADD_LITERAL, CSF_OP_SUB_W_FILE, CSF_OP_SUB_LITERAL: begin
        out_o.result = sum[7:0];
        out_o.nibble = low_sum[4];
        out_o.carry  = sum[8];
        out_o.upd_nibble = 1'b1;
        out_o.upd_carry  = 1'b1;
        out_o.upd_zero   = 1'b1;
      end
      CSF_OP_CLEAR_FILE: begin
        out_o.result   = 8'h00;
        out_o.upd_zero = 1'b1;
      end
      CSF_OP_LOGIC: begin
        out_o.result   = a_i & b_i;
        out_o.upd_zero = 1'b1;
      end
      CSF_OP_ROTATE_RIGHT: begin
        out_o.result    = {c_in_i, a_i[7:1]};
        out_o.carry     = a_i[0];
        out_o.upd_carry = 1'b1;
      end
      CSF_OP_ROTATE_LEFT: begin
        out_o.result    = {a_i[6:0], c_in_i};
        out_o.carry     = a_i[7];
        out_o.upd_carry = 1'b1;
      end
      CSF_OP_BIT_CLEAR:      out_o.result = a_i & ~(8'h01 << bit_i);
      CSF_OP_BIT_SET:        out_o.result = a_i | (8'h01 << bit_i);
      CSF_OP_NIBBLE_SWAP:    out_o.result = {a_i[3:0], a_i[7:4]};
      CSF_OP_MOVE_W_TO_FILE: out_o.result = b_i;
      CSF_OP_NONE:           out_o.result = a_i;
      default:               out_o.result = a_i;
    endcase
    out_o.zero = (out_o.result == 8'h00);
  end

endmodule // csf_alu

// file: verilog/csf_core.sv
// Purpose: status register with result flags, reset cause and bank selects
// Assumes: one instruction per valid cycle; Wishbone gives debug access
// Notes:   Wishbone writes behave like instruction writes for protected bits
////////////////////////////////////////////////////////////////////////////////
//
// The Wishbone slave port was left to the implementer.
module csf_core
  import csf_pkg::*;
(
  input  wire logic        clk_i,        // 50 MHz clock
  input  wire logic        rst_i,        // Sync reset, high
  input  csf_instr_s       instr_i,      // Instruction request
  input  wire logic        wdt_clear_i,  // Watchdog clear executed
  input  wire logic        sleep_i,      // Sleep executed
  input  wire logic        wdt_timeout_i,// Watchdog time-out
  output logic [7:0]       result_o,     // ALU result, registered
  output logic [8:0]       data_addr_o,  // Full data address, registered
  output logic             status_hit_o, // Access targets status
  output logic [7:0]       status_o,     // Status register
  input  wire logic        wb_cyc_i,     // Wishbone cycle
  input  wire logic        wb_stb_i,     // Wishbone strobe
  input  wire logic        wb_we_i,      // Wishbone write
  input  wire logic [3:0]  wb_adr_i,     // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,     // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,     // Wishbone write data
  output logic [31:0]      wb_dat_o,     // Wishbone read data
  output logic             wb_ack_o      // Wishbone ack
);

  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] event_reg;
  logic [8:0] addr_next;
  logic       hit;
  logic       file_wr;
  logic       wb_req;
  logic       wb_wr_status;
  logic       ack_reg;
  logic [31:0] rdata_reg;
  csf_alu_s   alu;

  ////////////////////////////////////////////////////////////////////////////
  // ALU
  csf_alu u_alu (
    .op_i   (instr_i.op),
    .a_i    (instr_i.a),
    .b_i    (instr_i.b),
    .bit_i  (instr_i.bit_sel),
    .c_in_i (status_reg[BIT_CARRY]),
    .out_o  (alu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address formation
  always_comb begin
    if (instr_i.indirect)
      addr_next = {status_reg[BIT_INDIRECT], instr_i.fsr};
    else
      addr_next = {status_reg[BIT_BANK_HI], status_reg[BIT_BANK_LO], instr_i.dir_addr};
    // mirror in all banks, bank bits ignored
    hit = (addr_next[6:0] == STATUS_DIRECT_OFS);
  end

  assign file_wr      = instr_i.valid && instr_i.dest_file && hit;
  assign wb_req       = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_wr_status = wb_req && wb_we_i && (wb_adr_i == WB_OFS_STATUS) && wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // Next status value
  always_comb begin
    status_next = status_reg;
    if (file_wr) begin
      status_next[7:5] = alu.result[7:5];
      if (!(alu.upd_zero || alu.upd_nibble || alu.upd_carry))
        status_next[2:0] = alu.result[2:0];
    end else if (wb_wr_status) begin
      status_next[7:5] = wb_dat_i[7:5];
      status_next[2:0] = wb_dat_i[2:0];
    end
    if (instr_i.valid) begin
      if (alu.upd_zero)   status_next[BIT_ZERO]   = alu.zero;
      if (alu.upd_nibble) status_next[BIT_NIBBLE] = alu.nibble;
      if (alu.upd_carry)  status_next[BIT_CARRY]  = alu.carry;
    end
    if (wdt_clear_i) begin
      status_next[BIT_WDOG]  = 1'b1;
      status_next[BIT_SLEEP] = 1'b1;
    end else if (sleep_i) begin
      status_next[BIT_WDOG]  = 1'b1;
      status_next[BIT_SLEEP] = 1'b0;
    end
    if (wdt_timeout_i)
      status_next[BIT_WDOG] = 1'b0;
  end

  // Status register, power-up value
  always_ff @(posedge clk_i) begin
    if (rst_i)
      status_reg <= STATUS_RESET;
    else
      status_reg <= status_next;
  end

  // Datapath outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_o    <= 8'h00;
      data_addr_o <= 9'h000;
    end else if (instr_i.valid) begin
      result_o    <= alu.result;
      data_addr_o <= addr_next;
    end
  end

  // Sticky event record: time-out, sleep, wdt clear; write 1 clears, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i)
      event_reg <= 8'h00;
    else
      event_reg <= (event_reg & ~((wb_req && wb_we_i && wb_adr_i == WB_OFS_EVENT &&
                   wb_sel_i[0]) ? wb_dat_i[7:0] : 8'h00))
                   | {5'h00, wdt_clear_i, sleep_i, wdt_timeout_i};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after request, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          WB_OFS_STATUS: rdata_reg <= {24'h000000, status_reg};
          WB_OFS_EVENT:  rdata_reg <= {24'h000000, event_reg};
          default:       rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o     = ack_reg;
  assign wb_dat_o     = rdata_reg;
  assign status_o     = status_reg;
  assign status_hit_o = hit;

endmodule // csf_core

// file: verilog/csf_pkg.sv
// Purpose: constants and carrier types for the core status flags block
// Assumes: one clock, synchronous active-high reset, classic Wishbone slave
// Notes:   status register holds result flags, reset cause and bank selects
////////////////////////////////////////////////////////////////////////////////
package csf_pkg;

  // Register bit positions
  localparam int unsigned BIT_CARRY    = 0;
  localparam int unsigned BIT_NIBBLE   = 1;
  localparam int unsigned BIT_ZERO     = 2;
  localparam int unsigned BIT_SLEEP    = 3;
  localparam int unsigned BIT_WDOG     = 4;
  localparam int unsigned BIT_BANK_LO  = 5;
  localparam int unsigned BIT_BANK_HI  = 6;
  localparam int unsigned BIT_INDIRECT = 7;

  // Reset value: banks 0, expiry and sleep flags 1, result flags 0
  localparam logic [7:0] STATUS_RESET = 8'h18;

  // Data-memory map of the status register (low 7 bits, any bank)
  localparam logic [6:0] STATUS_DIRECT_OFS = 7'h03;
  localparam logic [8:0] STATUS_ADDR_B0    = 9'h003;
  localparam logic [8:0] STATUS_ADDR_B3    = 9'h183;

  // Wishbone word offsets (byte addresses)
  localparam logic [3:0] WB_OFS_STATUS = 4'h0;
  localparam logic [3:0] WB_OFS_EVENT  = 4'h4;

  // Widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 9;

  // Operation selectors from the instruction datapath
  typedef enum logic [3:0] {
    CSF_OP_NONE,
    CSF_OP_MOVE_W_TO_FILE,
    CSF_OP_BIT_CLEAR,
    CSF_OP_BIT_SET,
    CSF_OP_NIBBLE_SWAP,
    CSF_OP_CLEAR_FILE,
    CSF_OP_ADD_W_FILE,
    CSF_OP_ADD_LITERAL,
    CSF_OP_SUB_W_FILE,
    CSF_OP_SUB_LITERAL,
    CSF_OP_LOGIC,
    CSF_OP_ROTATE_RIGHT,
    CSF_OP_ROTATE_LEFT
  } csf_op_e;

  // Instruction request from the execution datapath
  typedef struct packed {
    logic             valid;
    csf_op_e          op;
    logic [7:0]       a;        // File/first operand
    logic [7:0]       b;        // W/second operand
    logic [2:0]       bit_sel;  // Bit index for bit ops
    logic             dest_file;
    logic             indirect;
    logic [7:0]       fsr;      // Indirect pointer
    logic [6:0]       dir_addr; // Direct address field
  } csf_instr_s;

  // ALU outcome
  typedef struct packed {
    logic [7:0] result;
    logic       zero;
    logic       nibble;
    logic       carry;
    logic       upd_zero;
    logic       upd_nibble;
    logic       upd_carry;
  } csf_alu_s;

endpackage
